/* File: ssf_pkg.sv */
// Package for the serial port status block: register map, status field
// positions, control field positions and reset values.
// Assumes a 32-bit register port with byte addresses.
package ssf_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;

  // Status field positions
  localparam int RX_COUNT_LSB = 24;
  localparam int TX_COUNT_LSB = 16;
  localparam int COUNT_W = 5;
  localparam int BIT_FRAME_ERR = 12;
  localparam int BIT_ACTIVE = 11;
  localparam int BIT_TX_UNDERRUN = 8;
  localparam int BIT_SHIFTER_EMPTY = 7;
  localparam int BIT_RX_OVERFLOW = 6;
  localparam int BIT_RX_EMPTY = 5;
  localparam int BIT_TX_EMPTY = 3;
  localparam int BIT_TX_FULL = 1;
  localparam int BIT_RX_FULL = 0;

  // Control field positions
  localparam int BIT_CTRL_ENABLE = 0;
  localparam int BIT_CTRL_ENH = 1;
  localparam int BIT_CTRL_FRAMED = 2;

  // Reset values
  localparam logic [31:0] STATUS_RESET = 32'h0000_0008;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Buffer depth and word width
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = 32;

endpackage

/* File: ssf_mem.sv */
// Small word memory for the receive and transmit buffers.
// Assumes one writer and one reader on clk; the read address is the
// next head pointer, so q always holds the current head word.
`timescale 1ns/1ps
`default_nettype none

module ssf_mem #(
  parameter int DEPTH = ssf_pkg::FIFO_DEPTH,
  parameter int W = ssf_pkg::WORD_W,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] q;
  } ssf_mem_state_t;

  ssf_mem_state_t st_ff;
  ssf_mem_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Write-first bypass so a word written into an empty buffer is the head
  always_comb begin
    nxt_st = st_ff;
    if (we) begin
      nxt_st.mem[waddr] = wdata;
    end
    nxt_st.q = (we && waddr == raddr) ? wdata : st_ff.mem[raddr];
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

endmodule

`default_nettype wire

/* File: ssf_skid.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may stall for any time; nothing is lost.
`timescale 1ns/1ps
`default_nettype none

module ssf_skid #(
  parameter int W = ssf_pkg::WORD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  typedef struct packed {
    logic head_v;
    logic [W-1:0] head_d;
    logic spare_v;
    logic [W-1:0] spare_d;
  } ssf_skid_state_t;

  ssf_skid_state_t st_ff;
  ssf_skid_state_t nxt_st;
  logic accept;
  logic drain;

  ////////////////////////////////////////////////////////////////////////
  // Ready comes from the spare slot alone, so it is a plain flop output
  assign accept = in_valid && !st_ff.spare_v;
  assign drain = st_ff.head_v && out_ready;

  // Move words forward; spare only fills while the head is stalled
  always_comb begin
    nxt_st = st_ff;
    if (drain) begin
      if (st_ff.spare_v) begin
        nxt_st.head_d = st_ff.spare_d;
        nxt_st.spare_v = 1'b0;
      end else begin
        nxt_st.head_v = accept;
        nxt_st.head_d = accept ? in_data : st_ff.head_d;
      end
    end else if (accept) begin
      if (!st_ff.head_v) begin
        nxt_st.head_v = 1'b1;
        nxt_st.head_d = in_data;
      end else begin
        nxt_st.spare_v = 1'b1;
        nxt_st.spare_d = in_data;
      end
    end
    if (flush) begin
      nxt_st.head_v = 1'b0;
      nxt_st.spare_v = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready = !st_ff.spare_v;
  assign out_valid = st_ff.head_v;
  assign out_data = st_ff.head_d;

endmodule

`default_nettype wire

/* File: ssf_status.sv */
// Serial port status block: status register, control register, receive
// and transmit buffers, and the word path to the serial shifter.
// Assumes the shifter runs on clk and drives its event pulses for one
// cycle; software uses the plain register port with one-cycle strobes.
//
// Functional notes
// - Receive fill count in bits 28:24
// - Transmit fill count in bits 20:16
// - Frame error sets bit 12, framed only, clearable
// - Bit 11 shows shifter busy
// - Transmit underrun sets bit 8, framed only
// - Underrun cleared by disable or write zero
// - Bit 7 shows shift register empty
// - Overflow sets bit 6, new word dropped
// - Overflow hardware-set, cleared by disable/write zero
// - Bit 5 high when read pointer equals write, enhanced buffering only
// - Unimplemented status bits read zero
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ssf_status #(
  parameter int DEPTH = ssf_pkg::FIFO_DEPTH,
  parameter int W = ssf_pkg::WORD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Control outputs to the shifter
  output logic port_enable,
  output logic enhanced_buffer_select,
  output logic framed_operation_enable,
  // Received words from the shifter
  input wire logic rx_valid,
  input wire logic [W-1:0] rx_data,
  // Words to transmit
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [W-1:0] tx_data,
  // Shifter state and events
  input wire logic shifter_busy,
  input wire logic shifter_idle_empty,
  input wire logic frame_error_evt,
  input wire logic tx_underrun_evt
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] CAP_ENH = PW'(DEPTH);
  localparam logic [PW-1:0] CAP_ONE = PW'(1);

  typedef struct packed {
    logic enable;
    logic enh;
    logic framed;
    logic [PW-1:0] rx_wr;
    logic [PW-1:0] rx_rd;
    logic [PW-1:0] tx_wr;
    logic [PW-1:0] tx_rd;
    logic frame_error_flag;
    logic tx_underrun_flag;
    logic rx_overflow_flag;
    logic port_active_flag;
    logic shifter_empty_flag;
    logic [31:0] rdata;
  } ssf_state_t;

  ssf_state_t st_ff;
  ssf_state_t nxt_st;

  logic [PW-1:0] cap;
  logic [PW-1:0] rx_count;
  logic [PW-1:0] tx_count;
  logic rx_fifo_empty_flag;
  logic rx_buffer_full_flag;
  logic tx_buffer_empty_flag;
  logic tx_buffer_full_flag;
  logic wr_status;
  logic wr_ctrl;
  logic wr_data;
  logic rd_data;
  logic rx_push;
  logic rx_drop;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic skid_in_ready;
  logic [W-1:0] rx_head;
  logic [W-1:0] tx_head;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////
  // Pointer arithmetic

  // Pointers carry one wrap bit so full and empty differ
  function automatic logic [AW-1:0] ptr_addr(input logic [PW-1:0] p);
    ptr_addr = p[AW-1:0];
  endfunction

  // Capacity is one word unless enhanced buffering is selected
  assign cap = st_ff.enh ? CAP_ENH : CAP_ONE;

  assign rx_count = st_ff.rx_wr - st_ff.rx_rd;
  assign tx_count = st_ff.tx_wr - st_ff.tx_rd;
  assign rx_fifo_empty_flag = (st_ff.rx_rd == st_ff.rx_wr);
  assign rx_buffer_full_flag = (rx_count >= cap);
  assign tx_buffer_empty_flag = (st_ff.tx_rd == st_ff.tx_wr);
  assign tx_buffer_full_flag = (tx_count >= cap);

  ////////////////////////////////////////////////////////////////////////
  // Register port decode

  assign wr_status = reg_wr && reg_addr == ssf_pkg::ADDR_STATUS;
  assign wr_ctrl = reg_wr && reg_addr == ssf_pkg::ADDR_CTRL;
  assign wr_data = reg_wr && reg_addr == ssf_pkg::ADDR_DATA;
  assign rd_data = reg_rd && reg_addr == ssf_pkg::ADDR_DATA;

  ////////////////////////////////////////////////////////////////////////
  // Word movement

  assign rx_push = st_ff.enable && rx_valid && !rx_buffer_full_flag;
  assign rx_drop = st_ff.enable && rx_valid && rx_buffer_full_flag;
  // Reading an empty buffer returns a stale word and moves nothing
  assign rx_pop = st_ff.enable && rd_data && !rx_fifo_empty_flag;
  // A write to a full transmit buffer is ignored
  assign tx_push = st_ff.enable && wr_data && !tx_buffer_full_flag;
  assign tx_pop = st_ff.enable && !tx_buffer_empty_flag && skid_in_ready;

  ////////////////////////////////////////////////////////////////////////
  // Status word assembly

  always_comb begin
    status_word = '0;
    status_word[ssf_pkg::RX_COUNT_LSB +: ssf_pkg::COUNT_W] =
      ssf_pkg::COUNT_W'(rx_count);
    status_word[ssf_pkg::TX_COUNT_LSB +: ssf_pkg::COUNT_W] =
      ssf_pkg::COUNT_W'(tx_count);
    status_word[ssf_pkg::BIT_FRAME_ERR] = st_ff.frame_error_flag;
    status_word[ssf_pkg::BIT_ACTIVE] = st_ff.port_active_flag;
    status_word[ssf_pkg::BIT_TX_UNDERRUN] = st_ff.tx_underrun_flag;
    status_word[ssf_pkg::BIT_SHIFTER_EMPTY] = st_ff.shifter_empty_flag;
    status_word[ssf_pkg::BIT_RX_OVERFLOW] = st_ff.rx_overflow_flag;
    // empty only shown with enhanced buffering
    // Reads zero otherwise, so the reset view keeps only transmit-empty set
    status_word[ssf_pkg::BIT_RX_EMPTY] = st_ff.enh && rx_fifo_empty_flag;
    status_word[ssf_pkg::BIT_TX_EMPTY] = tx_buffer_empty_flag;
    status_word[ssf_pkg::BIT_TX_FULL] = tx_buffer_full_flag;
    status_word[ssf_pkg::BIT_RX_FULL] = rx_buffer_full_flag;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;

    // Control register; mode bits follow software directly
    if (wr_ctrl) begin
      nxt_st.enable = reg_wdata[ssf_pkg::BIT_CTRL_ENABLE];
      nxt_st.enh = reg_wdata[ssf_pkg::BIT_CTRL_ENH];
      nxt_st.framed = reg_wdata[ssf_pkg::BIT_CTRL_FRAMED];
    end

    // Pointers advance only on accepted moves
    if (rx_push) begin
      nxt_st.rx_wr = st_ff.rx_wr + PW'(1);
    end
    if (rx_pop) begin
      nxt_st.rx_rd = st_ff.rx_rd + PW'(1);
    end
    if (tx_push) begin
      nxt_st.tx_wr = st_ff.tx_wr + PW'(1);
    end
    if (tx_pop) begin
      nxt_st.tx_rd = st_ff.tx_rd + PW'(1);
    end

    // Software clears a sticky flag by writing zero to it
    if (wr_status && !reg_wdata[ssf_pkg::BIT_FRAME_ERR]) begin
      nxt_st.frame_error_flag = 1'b0;
    end
    if (wr_status && !reg_wdata[ssf_pkg::BIT_TX_UNDERRUN]) begin
      nxt_st.tx_underrun_flag = 1'b0;
    end
    if (wr_status && !reg_wdata[ssf_pkg::BIT_RX_OVERFLOW]) begin
      nxt_st.rx_overflow_flag = 1'b0;
    end

    // Hardware sets after the clear, so a same-cycle event survives
    // frame error in framed mode
    if (st_ff.enable && st_ff.framed && frame_error_evt) begin
      nxt_st.frame_error_flag = 1'b1;
    end
    if (st_ff.enable && st_ff.framed && tx_underrun_evt) begin
      nxt_st.tx_underrun_flag = 1'b1;
    end
    if (rx_drop) begin
      nxt_st.rx_overflow_flag = 1'b1;
    end

    nxt_st.port_active_flag = st_ff.enable && shifter_busy;
    nxt_st.shifter_empty_flag = st_ff.enable && shifter_idle_empty;

    if (!st_ff.enable) begin
      nxt_st.rx_wr = '0;
      nxt_st.rx_rd = '0;
      nxt_st.tx_wr = '0;
      nxt_st.tx_rd = '0;
      nxt_st.frame_error_flag = 1'b0;
      nxt_st.tx_underrun_flag = 1'b0;
      nxt_st.rx_overflow_flag = 1'b0;
    end

    // Read data land one cycle after the strobe; unmapped reads zero
    nxt_st.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == ssf_pkg::ADDR_STATUS) begin
        nxt_st.rdata = status_word;
      end else if (reg_addr == ssf_pkg::ADDR_CTRL) begin
        nxt_st.rdata[ssf_pkg::BIT_CTRL_ENABLE] = st_ff.enable;
        nxt_st.rdata[ssf_pkg::BIT_CTRL_ENH] = st_ff.enh;
        nxt_st.rdata[ssf_pkg::BIT_CTRL_FRAMED] = st_ff.framed;
      end else if (reg_addr == ssf_pkg::ADDR_DATA) begin
        nxt_st.rdata = 32'(rx_head);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffers

  // Receive words; read address is the next head so q is the head
  ssf_mem #(
    .DEPTH(DEPTH),
    .W(W),
    .AW(AW)
  ) u_rx_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(rx_push),
    .waddr(ptr_addr(st_ff.rx_wr)),
    .wdata(rx_data),
    .raddr(ptr_addr(nxt_st.rx_rd)),
    .q(rx_head)
  );

  // Transmit words waiting for the shifter
  ssf_mem #(
    .DEPTH(DEPTH),
    .W(W),
    .AW(AW)
  ) u_tx_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(tx_push),
    .waddr(ptr_addr(st_ff.tx_wr)),
    .wdata(reg_wdata[W-1:0]),
    .raddr(ptr_addr(nxt_st.tx_rd)),
    .q(tx_head)
  );

  // Stall by the shifter holds words here and back-pressures the buffer
  ssf_skid #(
    .W(W)
  ) u_tx_skid (
    .clk(clk),
    .rst_n(rst_n),
    .flush(!st_ff.enable),
    .in_valid(st_ff.enable && !tx_buffer_empty_flag),
    .in_ready(skid_in_ready),
    .in_data(tx_head),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs from flops

  assign reg_rdata = st_ff.rdata;
  assign port_enable = st_ff.enable;
  assign enhanced_buffer_select = st_ff.enh;
  assign framed_operation_enable = st_ff.framed;

endmodule

`default_nettype wire

/* File: ssf_status_monitor.sv */
// Checker for the serial port status block.
// Sees only the top ports; bound into every ssf_status.
`timescale 1ns/1ps
`default_nettype none
module ssf_status_monitor #(
  parameter int DEPTH = ssf_pkg::FIFO_DEPTH,
  parameter int W = ssf_pkg::WORD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Control
  input wire logic port_enable,
  input wire logic enhanced_buffer_select,
  input wire logic framed_operation_enable,
  // Shifter side
  input wire logic rx_valid,
  input wire logic [W-1:0] rx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [W-1:0] tx_data,
  input wire logic shifter_busy,
  input wire logic shifter_idle_empty,
  input wire logic frame_error_evt,
  input wire logic tx_underrun_evt
);
  logic st_rd;
  logic st_wr;
  logic on;
  // Status strobes decoded once
  assign st_rd = reg_rd && reg_addr == ssf_pkg::ADDR_STATUS;
  assign st_wr = reg_wr && reg_addr == ssf_pkg::ADDR_STATUS;
  assign on = port_enable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////
  a_unimpl_zero: assert property (st_rd |=> (reg_rdata & 32'hE0E0_E610) == 32'h0)
    else $error("reserved status bit set");
  a_active_follows: assert property (st_rd && on && $past(on) |=>
    reg_rdata[11] == $past(shifter_busy, 2)) else $error("activity flag wrong");
  a_shifter_empty: assert property (st_rd && on && $past(on) |=>
    reg_rdata[7] == $past(shifter_idle_empty, 2)) else $error("shifter empty wrong");
  a_rx_empty_count: assert property (st_rd && on && enhanced_buffer_select |=>
    reg_rdata[5] == (reg_rdata[28:24] == 5'h00)) else $error("rx empty disagrees");
  a_tx_empty_count: assert property (st_rd |=>
    reg_rdata[3] == (reg_rdata[20:16] == 5'h00)) else $error("tx empty disagrees");
  a_frame_set: assert property (frame_error_evt && on && framed_operation_enable ##1
    on && !st_wr ##1 st_rd && on |=> reg_rdata[12]) else $error("frame error lost");
  a_underrun_set: assert property (tx_underrun_evt && on && framed_operation_enable ##1
    on && !st_wr ##1 st_rd && on |=> reg_rdata[8]) else $error("underrun lost");
  a_underrun_wclr: assert property (st_wr && !reg_wdata[8] && !tx_underrun_evt ##1
    !tx_underrun_evt ##1 st_rd |=> !reg_rdata[8]) else $error("underrun not cleared");
  a_disable_clr: assert property (!on ##1 st_rd |=>
    (reg_rdata & 32'h0000_1140) == 32'h0) else $error("flag kept while off");
  // Main scenarios reached
  cover property (st_rd ##1 reg_rdata[6]);
  cover property (tx_valid && tx_ready && shifter_idle_empty);
  cover property (st_rd ##1 reg_rdata[12]);
endmodule
bind ssf_status ssf_status_monitor #(.DEPTH(DEPTH), .W(W)) u_ssf_status_monitor (.*);
`default_nettype wire

/* File: ssf_shifter_model.sv */
// Model of the serial shifter facing the status block.
// The bench asks for received words and may stall transmit.
`timescale 1ns/1ps
`default_nettype none
module ssf_shifter_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench requests
  input wire logic rx_go,
  input wire logic [31:0] rx_word,
  input wire logic stall,
  // Block side
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [31:0] rx_data,
  output logic shifter_busy,
  output logic shifter_idle_empty,
  // Observed traffic
  output logic [7:0] taken,
  output logic [31:0] last_word
);
  logic [1:0] hold_ff;
  // Busy two cycles per word, so transmit is slower than the bus
  assign tx_ready = !stall && hold_ff == 2'h0;
  assign shifter_busy = hold_ff != 2'h0;
  assign shifter_idle_empty = hold_ff == 2'h0;
  // Idle data line toggles so a stale word never looks fresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {hold_ff, taken, rx_valid} <= '0;
      last_word <= 32'h0;
      rx_data <= 32'h0;
    end else begin
      rx_valid <= rx_go;
      rx_data <= rx_go ? rx_word : ~rx_data;
      hold_ff <= tx_valid && tx_ready ? 2'h2 : hold_ff - {1'b0, shifter_busy};
      if (tx_valid && tx_ready) begin
        taken <= taken + 8'h01;
        last_word <= tx_data;
      end
    end
  end
endmodule
`default_nettype wire

/* File: spi_status_flags_tb.sv */
// Self-checking bench for the serial port status block.
// Shifter model on the far side; registers over the plain port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module spi_status_flags_tb;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
  } ssf_row_t;
  logic clk, rst_n, reg_wr, reg_rd, port_enable, enhanced_buffer_select;
  logic framed_operation_enable, rx_valid, tx_valid, tx_ready, shifter_busy;
  logic shifter_idle_empty, frame_error_evt, tx_underrun_evt, rx_go, stall;
  logic [7:0] reg_addr, taken;
  logic [31:0] reg_wdata, reg_rdata, rx_data, tx_data, rx_word, last_word, r;
  int errors, samples_checked, n;
  ssf_row_t rows [9];
  ssf_status u_ssf_status (.*);
  ssf_shifter_model u_ssf_shifter_model (.*);
  //////////////////////////////////////////////////////////////////
  // Bus cycles: strobe one cycle, read data taken in the next
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic st(input logic [31:0] e);
    rd(8'h00, r);
    `CHK("status", e, r)
  endtask
  task automatic rx(input logic [31:0] w);
    @(posedge clk);
    rx_go <= 1'b1;
    rx_word <= w;
    @(posedge clk);
    rx_go <= 1'b0;
  endtask
  task automatic evt();
    @(posedge clk);
    frame_error_evt <= 1'b1;
    tx_underrun_evt <= 1'b1;
    @(posedge clk);
    frame_error_evt <= 1'b0;
    tx_underrun_evt <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, rx_go, stall, frame_error_evt, tx_underrun_evt} = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rx_word = 32'h0;
    rows = '{'{1'b0, 8'h04, 32'h0}, '{1'b0, 8'h00, 32'h8}, '{1'b1, 8'h04, 32'h7},
      '{1'b0, 8'h04, 32'h7}, '{1'b1, 8'h0C, 32'hFFFF_FFFF}, '{1'b0, 8'h0C, 32'h0},
      '{1'b0, 8'h04, 32'h7}, '{1'b1, 8'h00, 32'h0}, '{1'b0, 8'h00, 32'hA8}};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Ordinary accesses from the table
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, r);
        `CHK("row read", rows[i].d, r)
      end
    end
    `CHK("mode", 3'h7, {framed_operation_enable, enhanced_buffer_select, port_enable})
    // Fill receive buffer, overflow, write-one keeps, write-zero clears
    for (int i = 0; i < 16; i++) rx(32'hA500_0000 + i);
    st(32'h1000_0089);
    rx(32'hDEAD_0000);
    st(32'h1000_00C9);
    wr(8'h00, 32'h0000_0040);
    st(32'h1000_00C9);
    wr(8'h00, 32'h0);
    st(32'h1000_0089);
    for (int i = 0; i < 16; i++) begin
      rd(8'h08, r);
      `CHK("rx word", 32'hA500_0000 + i, r)
    end
    st(32'h0000_00A8);
    // Transmit with the far side stalled, then drained
    stall <= 1'b1;
    for (int i = 0; i < 19; i++) wr(8'h08, 32'hC300_0000 + i);
    st(32'h0010_00A2);
    stall <= 1'b0;
    n = 0;
    // Look just after the edge, once the model's count has settled
    while (taken !== 8'd18 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("taken", 8'd18, taken)
    `CHK("last word", 32'hC300_0011, last_word)
    // Shifter still busy with the last word at this read
    st(32'h0000_0828);
    st(32'h0000_00A8);
    // Event flags: set, clear by write zero, clear by off and on
    evt();
    st(32'h0000_11A8);
    wr(8'h00, 32'h0000_0100);
    st(32'h0000_01A8);
    wr(8'h00, 32'h0);
    st(32'h0000_00A8);
    evt();
    wr(8'h04, 32'h6);
    st(32'h0000_0028);
    wr(8'h04, 32'h7);
    st(32'h0000_00A8);
    wr(8'h04, 32'h3);
    evt();
    st(32'h0000_00A8);
    `CHK("mode", 3'h3, {framed_operation_enable, enhanced_buffer_select, port_enable})
    // Reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    st(32'h0000_0008);
    tally_and_finish();
  end
endmodule
`default_nettype wire
